// ===== iso_snoop_packet_format.v
// isochronous transmit, isochronous receive and snoop receive quadlet framer
// What this block does
// - request bus after cycle start
// - data length gives payload byte count
// - tag 00 formatted, others reserved
// - speed code 00/01/10 selects rate
// - sync bits pass through unchanged
// - header length sets received byte count
// - block last flag marks final block
// - snoop header reports data quadlet count
// - status complete, data or checksum error
// - received iso tcode is Ah
// - rx byte 0 first, last iso quadlet padded
// - snoop mode captures every bus packet unless the rx fifo is full at its start
// - snoop header bit 12 mirrors enable
// - snoop header bit 11 always one
// - snoop header records observed ack
// - snoop header records packet rate
// - snoop status complete only if intact
// - store snooped packet or what fits
//
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`include "iso_snoop_defines.vh"
module iso_snoop_packet_format (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // link side: isochronous transmit
  input  wire        cycle_start,
  output reg         bus_request,
  input  wire        bus_grant,
  output reg         tx_valid,
  output reg  [31:0] tx_quadlet,
  input  wire        tx_ready,
  // link side: receive
  input  wire        rx_start,
  input  wire        rx_valid,
  input  wire [31:0] rx_quadlet,
  input  wire        rx_end,
  input  wire        rx_crc_ok,
  input  wire        rx_data_ok,
  input  wire [1:0]  rx_speed,
  input  wire [3:0]  rx_tcode,
  input  wire [3:0]  rx_observed_ack,
  input  wire        rx_for_us
);
  localparam ST_IDLE = 2'd0;
  localparam ST_HDR  = 2'd1;
  localparam ST_DATA = 2'd2;
  localparam ST_DONE = 2'd3;

  // bus address phase capture
  reg        wr_q;
  reg [7:0]  addr_q;
  reg [31:0] ctrl_q;
  wire       snoop_enable_flag = ctrl_q[`CTRL_SNOOP_BIT];

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  wire take = hsel & hready & htrans[1];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_q   <= take & hwrite;
      addr_q <= haddr;
    end
  end

  // transmit fifo: host writes quadlets in send order
  reg [31:0] tx_mem [0:`FIFO_DEPTH-1];
  reg [`FIFO_AW:0] tx_wp_q;
  reg [`FIFO_AW:0] tx_rp_q;
  wire tx_empty = (tx_wp_q == tx_rp_q);
  wire tx_full  = (tx_wp_q[`FIFO_AW-1:0] == tx_rp_q[`FIFO_AW-1:0]) &&
                  (tx_wp_q[`FIFO_AW] != tx_rp_q[`FIFO_AW]);
  // writes to a full fifo are dropped; software polls status first
  wire tx_push = wr_q && (addr_q == `REG_TXDATA) && !tx_full;

  // tx sequencing: header quadlet carries the length for the payload count
  reg [1:0]  tx_st_q;
  reg [13:0] tx_left_q;
  wire [31:0] tx_head = tx_mem[tx_rp_q[`FIFO_AW-1:0]];
  wire tx_pop = tx_valid & tx_ready;
  // byte count plus three, quartered below to round up to whole quadlets
  wire [15:0] tx_len_up = tx_head[31:16] + 16'd3;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_wp_q     <= {(`FIFO_AW+1){1'b0}};
      tx_rp_q     <= {(`FIFO_AW+1){1'b0}};
      tx_st_q     <= ST_IDLE;
      tx_left_q   <= 14'h0000;
      bus_request <= 1'b0;
      tx_valid    <= 1'b0;
      tx_quadlet  <= 32'h00000000;
      ctrl_q      <= `CTRL_RESET;
    end else begin
      if (wr_q && addr_q == `REG_CTRL)
        ctrl_q <= hwdata;
      if (tx_push) begin
        tx_mem[tx_wp_q[`FIFO_AW-1:0]] <= hwdata;
        tx_wp_q <= tx_wp_q + 1'b1;
      end
      case (tx_st_q)
        ST_IDLE: begin
          // queued packets only go out after a cycle start
          if (cycle_start && !tx_empty) begin
            bus_request <= 1'b1;
            tx_st_q     <= ST_HDR;
          end
        end
        ST_HDR: begin
          if (bus_grant && !tx_valid && !tx_empty) begin
            bus_request <= 1'b0;
            // header fields (length, tag, channel, speed, sync) pass untouched
            tx_quadlet  <= tx_head;
            tx_valid    <= 1'b1;
            // payload quadlets from byte count, rounding up
            tx_left_q   <= tx_len_up[15:2];
            tx_rp_q     <= tx_rp_q + 1'b1;
          end else if (tx_pop) begin
            tx_valid <= 1'b0;
            tx_st_q  <= (tx_left_q == 14'h0000) ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (tx_pop) begin
            tx_valid  <= 1'b0;
            tx_left_q <= tx_left_q - 1'b1;
            if (tx_left_q == 14'h0001)
              tx_st_q <= ST_IDLE;
          end else if (!tx_valid && !tx_empty) begin
            // payload is already byte 0 first and zero padded by the host
            tx_quadlet <= tx_head;
            tx_valid   <= 1'b1;
            tx_rp_q    <= tx_rp_q + 1'b1;
          end
        end
        default: tx_st_q <= ST_IDLE;
      endcase
    end
  end

  // general receive fifo, headers written back after the payload
  reg [31:0] general_receive_fifo [0:`FIFO_DEPTH-1];
  reg [`FIFO_AW:0] rx_wp_q;
  reg [`FIFO_AW:0] rx_rp_q;
  reg [`FIFO_AW:0] rx_hdr_q;
  reg [1:0]  rx_st_q;
  reg [15:0] rx_bytes_q;
  reg [13:0] quadlet_count;
  reg        rx_snoop_q;
  reg        rx_trunc_q;
  reg [3:0]  rx_error_status;
  reg [1:0]  rx_spd_q;
  reg [31:0] rx_hdr_word_q;
  // one-cycle marker that a header slot awaits its final word
  reg        hdr_pend_q;
  wire [`FIFO_AW:0] rx_level = rx_wp_q - rx_rp_q;
  wire rx_full  = rx_level[`FIFO_AW];
  wire rx_empty = (rx_level == {(`FIFO_AW+1){1'b0}});
  // pop in the address phase so the word stands in the data phase
  wire rx_pop   = take && !hwrite && (haddr == `REG_RXDATA) && !rx_empty;
  // accept iso packets for us, or everything when snooping
  wire rx_accept = rx_start && (rx_for_us || snoop_enable_flag);

  // byte mask for last iso quadlet, byte 0 is msb lane
  reg [31:0] pad_mask;
  always @* begin
    case (rx_bytes_q[1:0])
      2'd1:    pad_mask = 32'hFF000000;
      2'd2:    pad_mask = 32'hFFFF0000;
      2'd3:    pad_mask = 32'hFFFFFF00;
      default: pad_mask = 32'hFFFFFFFF;
    endcase
  end
  wire last_iso_q = !rx_snoop_q && (rx_bytes_q <= 16'd4);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_wp_q         <= {(`FIFO_AW+1){1'b0}};
      rx_rp_q         <= {(`FIFO_AW+1){1'b0}};
      rx_hdr_q        <= {(`FIFO_AW+1){1'b0}};
      rx_st_q         <= ST_IDLE;
      rx_bytes_q      <= 16'h0000;
      quadlet_count   <= 14'h0000;
      rx_snoop_q      <= 1'b0;
      rx_trunc_q      <= 1'b0;
      rx_error_status <= `ACK_COMPLETE;
      rx_spd_q        <= `SPD_100;
      rx_hdr_word_q   <= 32'h00000000;
      hrdata          <= 32'h00000000;
    end else begin
      if (rx_pop)
        rx_rp_q <= rx_rp_q + 1'b1;
      case (rx_st_q)
        ST_IDLE: begin
          if (rx_accept && !rx_full) begin
            // reserve the header slot; it is filled when the packet ends
            rx_hdr_q      <= rx_wp_q;
            rx_wp_q       <= rx_wp_q + 1'b1;
            rx_snoop_q    <= snoop_enable_flag;
            rx_spd_q      <= rx_speed;
            rx_trunc_q    <= 1'b0;
            quadlet_count <= 14'h0000;
            rx_st_q       <= snoop_enable_flag ? ST_DATA : ST_HDR;
          end
        end
        ST_HDR: begin
          if (rx_valid) begin
            rx_hdr_word_q <= rx_quadlet;
            // payload length comes from the iso header
            rx_bytes_q    <= rx_quadlet[31:16];
            rx_st_q       <= (rx_quadlet[31:16] == 16'h0000) ? ST_DONE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (rx_valid && (rx_snoop_q || rx_bytes_q != 16'h0000)) begin
            if (!rx_full) begin
              // zero the unused lanes of the final iso quadlet
              general_receive_fifo[rx_wp_q[`FIFO_AW-1:0]] <=
                last_iso_q ? (rx_quadlet & pad_mask) : rx_quadlet;
              rx_wp_q       <= rx_wp_q + 1'b1;
              quadlet_count <= quadlet_count + 1'b1;
            end else
              rx_trunc_q <= 1'b1;
            if (!rx_snoop_q)
              rx_bytes_q <= (rx_bytes_q > 16'd4) ? rx_bytes_q - 16'd4 : 16'h0000;
          end
          if (rx_end)
            rx_st_q <= ST_DONE;
        end
        ST_DONE: begin
          // status uses ack encoding, complete only for intact data
          if (!rx_crc_ok)
            rx_error_status <= `ACK_CRC_ERR;
          else if (!rx_data_ok || rx_trunc_q)
            rx_error_status <= `ACK_DATA_ERR;
          else
            rx_error_status <= `ACK_COMPLETE;
          rx_st_q <= ST_IDLE;
        end
        default: rx_st_q <= ST_IDLE;
      endcase
      // header lands one cycle after status is known
      if (rx_st_q == ST_IDLE && hdr_pend_q)
        general_receive_fifo[rx_hdr_q[`FIFO_AW-1:0]] <= rx_snoop_q ?
          {rx_observed_ack, rx_spd_q, quadlet_count[12:0],
           1'b1, 1'b1, 3'b000, rx_tcode, rx_error_status} :
          {rx_hdr_word_q[31:16], rx_hdr_word_q[15:14], rx_hdr_word_q[13:8],
           `TCODE_ISO, rx_hdr_word_q[3:0]};
      // read data is registered in the address phase, zero wait states
      if (take && !hwrite) begin
        case (haddr)
          `REG_CTRL:    hrdata <= ctrl_q;
          `REG_STATUS:  hrdata <= {15'h0000, rx_spd_q, rx_error_status, quadlet_count[6:0],
                                   tx_full, tx_empty, rx_empty, rx_full};
          `REG_RXDATA:  hrdata <= rx_empty ? 32'h00000000 :
                                  general_receive_fifo[rx_rp_q[`FIFO_AW-1:0]];
          `REG_RXLEVEL: hrdata <= {{(31-`FIFO_AW){1'b0}}, rx_level};
          default:      hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hdr_pend_q <= 1'b0;
    else
      hdr_pend_q <= (rx_st_q == ST_DONE);
  end

  // last flag tied high, one block per packet; no stored header takes it from block_last_flag
  wire block_last_flag = 1'b1;
  wire payload_fault   = (rx_error_status == `ACK_DATA_ERR);
  wire checksum_fault  = (rx_error_status == `ACK_CRC_ERR);
endmodule

// ===== iso_snoop_defines.vh
// constants for the isochronous and snoop packet framer
`ifndef ISO_SNOOP_DEFINES_VH
`define ISO_SNOOP_DEFINES_VH
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_TXDATA      8'h08
`define REG_RXDATA      8'h0C
`define REG_RXLEVEL     8'h10
`define CTRL_SNOOP_BIT  0
`define CTRL_RESET      32'h00000000
`define TCODE_ISO       4'hA
`define TAG_FORMATTED   2'h0
`define SPD_100         2'h0
`define SPD_200         2'h1
`define SPD_400         2'h2
`define ACK_COMPLETE    4'h1
`define ACK_DATA_ERR    4'hD
`define ACK_CRC_ERR     4'hE
`define HDR_LAST_BIT    11
`define HDR_SNOOP_BIT   12
`define FIFO_DEPTH      16
`define FIFO_AW         4
`endif

// ===== iso_snoop_checker.sv
// port checker for the packet framer
module iso_snoop_checker (
  // clock and reset
  input wire        hclk,
  input wire        hresetn,
  // bus side
  input wire        hsel,
  input wire [7:0]  haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata,
  // link side
  input wire        cycle_start,
  input wire        bus_request,
  input wire        bus_grant,
  input wire        tx_valid,
  input wire [31:0] tx_quadlet,
  input wire        tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic armed_q;
  logic grant_q;
  wire  rd_a = hsel && hready && htrans[1] && !hwrite;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // a request needs a start pulse not yet answered by a grant
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_q <= 1'b0;
      grant_q <= 1'b0;
    end else begin
      armed_q <= cycle_start | (armed_q & ~bus_grant);
      grant_q <= grant_q | bus_grant;
    end
  end
  sequence s_stall; tx_valid && !tx_ready; endsequence
  sequence s_read; rd_a; endsequence
  property p_ready; hreadyout == 1'b1; endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_unmapped; s_read ##0 (haddr > 8'h10) |=> hrdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_hold; !rd_a |=> $stable(hrdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("hrdata moved");
  property p_valid_hold; s_stall |=> tx_valid; endproperty
  a_valid_hold: assert property (p_valid_hold) else $error("tx_valid dropped");
  property p_data_hold; s_stall |=> $stable(tx_quadlet); endproperty
  a_data_hold: assert property (p_data_hold) else $error("tx_quadlet moved");
  property p_req_cause; $rose(bus_request) |-> armed_q; endproperty
  a_req_cause: assert property (p_req_cause) else $error("request without start");
  property p_granted; tx_valid |-> grant_q; endproperty
  a_granted: assert property (p_granted) else $error("tx before grant");
endmodule
bind iso_snoop_packet_format iso_snoop_checker i_iso_snoop_checker (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .cycle_start(cycle_start), .bus_request(bus_request),
  .bus_grant(bus_grant), .tx_valid(tx_valid), .tx_quadlet(tx_quadlet), .tx_ready(tx_ready));

// ===== link_far_end.sv
// link side model: bus grant, stalling ready and packet source
module link_far_end (
  // clock and reset
  input  wire         hclk,
  input  wire         hresetn,
  // transmit side
  input  wire         bus_request,
  output logic        cycle_start,
  output logic        bus_grant,
  output logic        tx_ready,
  // receive side
  output logic        rx_start,
  output logic        rx_valid,
  output logic [31:0] rx_quadlet,
  output logic        rx_end,
  output logic        rx_crc_ok,
  output logic        rx_data_ok,
  output logic [1:0]  rx_speed,
  output logic [3:0]  rx_tcode,
  output logic [3:0]  rx_observed_ack,
  output logic        rx_for_us
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        sending;
  logic [31:0] qd;
  initial begin
    {cycle_start, rx_start, rx_end, sending, rx_for_us, qd} = '0;
    {rx_crc_ok, rx_data_ok, rx_speed, rx_tcode, rx_observed_ack} = '0;
  end
  // ready stalls every other cycle so the hold rules get exercised
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {bus_grant, tx_ready, rx_valid} <= 3'h0;
      rx_quadlet <= 32'h0;
    end else begin
      bus_grant <= bus_request;
      tx_ready <= ~tx_ready;
      rx_valid <= sending;
      // idle data toggles so a stale word never passes for a new one
      rx_quadlet <= sending ? qd : ~rx_quadlet;
    end
  end
  task automatic pulse_start();
    @(posedge hclk) cycle_start <= 1'b1;
    @(posedge hclk) cycle_start <= 1'b0;
  endtask
  // packet not addressed to us, intact, with the given rate and observed ack 1
  task automatic send(input int n, input logic [31:0] base, input logic [1:0] spd);
    @(posedge hclk);
    rx_start <= 1'b1;
    rx_speed <= spd;
    rx_observed_ack <= 4'h1;
    {rx_crc_ok, rx_data_ok, rx_tcode} <= {2'h3, 4'hA};
    for (int k = 0; k < n; k++) begin
      @(posedge hclk);
      rx_start <= 1'b0;
      sending <= 1'b1;
      qd <= base + k;
    end
    @(posedge hclk) sending <= 1'b0;
    @(posedge hclk);
    @(posedge hclk) rx_end <= 1'b1;
    @(posedge hclk) rx_end <= 1'b0;
  endtask
endmodule

// ===== iso_snoop_packet_format_bench.sv
// self-checking bench for the packet framer
`include "iso_snoop_defines.vh"
module iso_snoop_packet_format_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp, cycle_start, bus_request, bus_grant;
  logic tx_valid, tx_ready, rx_start, rx_valid, rx_end, rx_crc_ok, rx_data_ok, rx_for_us;
  logic [7:0] haddr;
  logic [1:0] htrans, rx_speed;
  logic [2:0] hsize;
  logic [3:0] rx_tcode, rx_observed_ack;
  logic [31:0] hwdata, hrdata, tx_quadlet, rx_quadlet, h, base;
  logic [31:0] exp_q[$];
  int seed, n_fail, total_checks, cyc;
  always #5 hclk = ~hclk;
  iso_snoop_packet_format i_iso_snoop_packet_format (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .cycle_start(cycle_start), .bus_request(bus_request),
    .bus_grant(bus_grant), .tx_valid(tx_valid), .tx_quadlet(tx_quadlet),
    .tx_ready(tx_ready), .rx_start(rx_start), .rx_valid(rx_valid),
    .rx_quadlet(rx_quadlet), .rx_end(rx_end), .rx_crc_ok(rx_crc_ok),
    .rx_data_ok(rx_data_ok), .rx_speed(rx_speed), .rx_tcode(rx_tcode),
    .rx_observed_ack(rx_observed_ack), .rx_for_us(rx_for_us));
  link_far_end i_link_far_end (.hclk(hclk), .hresetn(hresetn), .bus_request(bus_request),
    .cycle_start(cycle_start), .bus_grant(bus_grant), .tx_ready(tx_ready),
    .rx_start(rx_start), .rx_valid(rx_valid), .rx_quadlet(rx_quadlet), .rx_end(rx_end),
    .rx_crc_ok(rx_crc_ok), .rx_data_ok(rx_data_ok), .rx_speed(rx_speed),
    .rx_tcode(rx_tcode), .rx_observed_ack(rx_observed_ack), .rx_for_us(rx_for_us));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one single transfer; each phase waits until hreadyout is high, or the timeout ends it
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    {htrans, haddr, hwrite} <= {2'h2, a, wr};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    ahb(1'b1, a, d, unused);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string what);
    logic [31:0] d;
    ahb(1'b0, a, 32'h0, d);
    check(d & m, e, what);
  endtask
  // emitted quadlets are matched against the host's notes in order
  always @(posedge hclk) begin
    if (hresetn === 1'b1 && tx_valid === 1'b1 && tx_ready === 1'b1)
      check(tx_quadlet, exp_q.size() ? exp_q.pop_front() : ~tx_quadlet, "tx");
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    {seed, cyc, n_fail, total_checks} = {32'd21, 96'h0};
    hresetn = 1'b0;
    hsel = 1'b1;
    htrans = 2'h0;
    haddr = 8'h00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`REG_CTRL, 32'hFFFFFFFF, 32'h0, "ctrl");
    rd(`REG_STATUS, 32'hF, 32'h6, "status");
    rd(8'h40, 32'hFFFFFFFF, 32'h0, "unmapped");
    $display("test reset done");
    h = {16'h0008, `TAG_FORMATTED, 6'($random(seed)), `TCODE_ISO, 4'($random(seed))};
    wr(`REG_TXDATA, h);
    exp_q.push_back(h);
    for (int i = 0; i < 2; i++) begin
      h = $random(seed);
      wr(`REG_TXDATA, h);
      exp_q.push_back(h);
    end
    check({31'h0, bus_request}, 32'h0, "early_request");
    i_link_far_end.pulse_start();
    for (int t = 0; t < 200 && exp_q.size() > 0; t++) @(posedge hclk);
    check(32'(exp_q.size()), 32'h0, "tx_left");
    $display("test tx done");
    wr(`REG_CTRL, 32'h1);
    rd(`REG_CTRL, 32'h1, 32'h1, "snoop_on");
    for (int s = 0; s < 3; s++) begin
      base = $random(seed);
      i_link_far_end.send(3, base, 2'(s));
      repeat (5) @(posedge hclk);
      rd(`REG_RXLEVEL, 32'hFFFFFFFF, 32'h4, "rx_level");
      rd(`REG_RXDATA, 32'hFFFFFFFF, {4'h1, 2'(s), 13'd3, 2'h3, 3'h0, `TCODE_ISO, `ACK_COMPLETE},
         "snoop_hdr");
      for (int k = 0; k < 3; k++)
        rd(`REG_RXDATA, 32'hFFFFFFFF, base + k, "rx_data");
      rd(`REG_STATUS, 32'h2, 32'h2, "rx_empty");
    end
    $display("test snoop done");
    give_verdict();
  end
endmodule
